// ==== logic/dmach_top.sv ====
// Four-channel DMA programming registers, transfer sequencer and external handshake pins.
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dmach_top
  import dmach_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [7:0]            paddr_i,
  input  wire logic [31:0]           pwdata_i,
  output logic                       pready_o,
  output logic                       pslverr_o,
  output logic [31:0]                prdata_o,
  input  wire logic [NUM_EXT_CH-1:0] ext_request_in_i,
  output logic      [NUM_EXT_CH-1:0] ext_ack_out_o,
  output logic      [NUM_EXT_CH-1:0] xfer_end_out_o,
  output logic      [NUM_CH-1:0]     ch_busy_o
);
  logic [31:0]      src_r [NUM_CH];
  logic [31:0]      dst_r [NUM_CH];
  logic [CNT_W-1:0] cnt_r [NUM_CH];
  logic [31:0]      ctl_r [NUM_CH];

  dmach_state_t     state_r;
  dmach_state_t     state_nxt;
  logic [1:0]       cur_r;
  logic [1:0]       grant;
  logic             grant_ok;
  logic             finish;
  logic [NUM_CH-1:0] want;
  logic [NUM_CH-1:0] take;
  logic [NUM_CH-1:0] ext_use;
  logic [NUM_EXT_CH-1:0] pend;

  logic             wr_en;
  logic             rd_setup;
  logic [1:0]       wr_ch;
  logic [7:0]       wr_ofs;
  logic             mapped;
  logic [NUM_CH-1:0] wr_src;
  logic [NUM_CH-1:0] wr_dst;
  logic [NUM_CH-1:0] wr_cnt;
  logic [NUM_CH-1:0] wr_ctl;
  logic [NUM_CH-1:0] hw_step;
  logic [NUM_CH-1:0] hw_last;
  logic [31:0]      prdata_nxt;

  logic [3:0]       cur_rs;
  logic             cur_single;
  logic             cur_last;
  logic [1:0]       cur_sz;
  logic [1:0]       cur_sm;
  logic [1:0]       cur_dm;
  logic [31:0]      step;
  logic [31:0]      src_next;
  logic [31:0]      dst_next;

  ////////////////////////////////////////////////////////////////////////////////
  // APB decode: zero wait states, unmapped offsets answer with an error.
  assign mapped    = (paddr_i < MAP_END) && (paddr_i[1:0] == 2'b00);
  assign wr_en     = psel_i && penable_i && pwrite_i && mapped;
  assign rd_setup  = psel_i && !penable_i && !pwrite_i;
  assign wr_ch     = paddr_i[CH_SHIFT+1:CH_SHIFT];
  assign wr_ofs    = {4'h0, paddr_i[3:0]};
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;

  // Read data is picked in the setup cycle and held through the access phase.
  always_comb
  begin
    prdata_nxt = prdata_o;
    if (rd_setup && !mapped)
      prdata_nxt = 32'h0000_0000;
    else if (rd_setup)
    begin
      case (wr_ofs)
        OFS_SRC: prdata_nxt = src_r[wr_ch];
        OFS_DST: prdata_nxt = dst_r[wr_ch];
        OFS_CNT: prdata_nxt = {8'h00, cnt_r[wr_ch]};
        default: prdata_nxt = ctl_r[wr_ch];
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      prdata_o <= 32'h0000_0000;
    else
      prdata_o <= prdata_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Request sources: channels 0 and 1 may use their pins, the others run on auto request.
  genvar g;
  generate
    for (g = 0; g < NUM_EXT_CH; g++)
    begin : g_det
      dmach_req_det u_det (
        .clk_i         (clk_i),
        .sys_rst_i     (sys_rst_i),
        .req_pin_i     (ext_request_in_i[g]),
        .det_mode_i    (ctl_r[g][B_DET_LO+1:B_DET_LO]),
        .overrun_sel_i (ctl_r[g][B_DO]),
        .take_i        (take[g]),
        .pending_o     (pend[g])
      );
    end
  endgenerate

  always_comb
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      ext_use[c] = 1'b0;
      want[c]    = ctl_r[c][B_EN];
    end
    for (int c = 0; c < NUM_EXT_CH; c++)
    begin
      ext_use[c] = (ctl_r[c][B_RS_LO+3:B_RS_LO] == RS_EXT_DUAL) ||
                   (ctl_r[c][B_RS_LO+3:B_RS_LO] == RS_EXT_TOD)  ||
                   (ctl_r[c][B_RS_LO+3:B_RS_LO] == RS_EXT_FROM);
      want[c]    = ctl_r[c][B_EN] && (!ext_use[c] || pend[c]);
    end
  end

  // Fixed priority, channel 0 highest.
  always_comb
  begin
    grant    = 2'h0;
    grant_ok = 1'b0;
    for (int c = NUM_CH - 1; c >= 0; c--)
    begin
      if (want[c])
      begin
        grant    = 2'(c);
        grant_ok = 1'b1;
      end
    end
  end

  // Take pulses only in idle, so a latched edge is spent once per granted transfer.
  always_comb
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      take[c] = (state_r == ST_IDLE) && grant_ok && (grant == 2'(c));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer: dual address mode runs a read then a write cycle, single mode one cycle.
  assign cur_rs     = ctl_r[cur_r][B_RS_LO+3:B_RS_LO];
  assign cur_sz     = ctl_r[cur_r][B_SIZE_LO+1:B_SIZE_LO];
  assign cur_sm     = ctl_r[cur_r][B_SM_LO+1:B_SM_LO];
  assign cur_dm     = ctl_r[cur_r][B_DM_LO+1:B_DM_LO];
  assign cur_single = ext_use[cur_r] && (cur_rs != RS_EXT_DUAL);
  assign cur_last   = (cnt_r[cur_r] == CNT_LAST);
  assign finish     = (state_r == ST_WR) || ((state_r == ST_RD) && cur_single);

  always_comb
  begin
    case (state_r)
      ST_IDLE: state_nxt = grant_ok ? ST_RD : ST_IDLE;
      ST_RD:   state_nxt = cur_single ? ST_IDLE : ST_WR;
      ST_WR:   state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      cur_r <= 2'h0;
    else if (state_r == ST_IDLE && grant_ok)
      cur_r <= grant;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pointer stepping by transfer unit and address mode.
  always_comb
  begin
    // Sixteen-byte units step by a whole unit and still count as one transfer.
    case (cur_sz)
      SZ_BYTE: step = STEP_B;
      SZ_WORD: step = STEP_W;
      SZ_LONG: step = STEP_L;
      default: step = STEP_16;
    endcase
  end

  always_comb
  begin
    case (cur_sm)
      AM_INC:  src_next = src_r[cur_r] + step;
      AM_DEC:  src_next = src_r[cur_r] - step;
      default: src_next = src_r[cur_r];
    endcase
    if (cur_single && cur_rs == RS_EXT_FROM)
      src_next = src_r[cur_r];
  end

  always_comb
  begin
    case (cur_dm)
      AM_INC:  dst_next = dst_r[cur_r] + step;
      AM_DEC:  dst_next = dst_r[cur_r] - step;
      default: dst_next = dst_r[cur_r];
    endcase
    if (cur_single && cur_rs == RS_EXT_TOD)
      dst_next = dst_r[cur_r];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-channel strobes; a bus write outranks the hardware step in the same cycle.
  always_comb
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      wr_src[c]  = wr_en && (wr_ch == 2'(c)) && (wr_ofs == OFS_SRC);
      wr_dst[c]  = wr_en && (wr_ch == 2'(c)) && (wr_ofs == OFS_DST);
      wr_cnt[c]  = wr_en && (wr_ch == 2'(c)) && (wr_ofs == OFS_CNT);
      wr_ctl[c]  = wr_en && (wr_ch == 2'(c)) && (wr_ofs == OFS_CTL);
      hw_step[c] = finish && (cur_r == 2'(c));
      hw_last[c] = hw_step[c] && cur_last;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pointer and count storage carries no reset.
  always_ff @(posedge clk_i)
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      if (wr_src[c])
        src_r[c] <= pwdata_i;
      else if (hw_step[c])
        src_r[c] <= src_next;
    end
  end

  always_ff @(posedge clk_i)
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      if (wr_dst[c])
        dst_r[c] <= pwdata_i;
      else if (hw_step[c])
        dst_r[c] <= dst_next;
    end
  end

  // Zero counts as the full range because the decrement wraps to all ones.
  always_ff @(posedge clk_i)
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      if (wr_cnt[c])
        cnt_r[c] <= pwdata_i[CNT_W-1:0];
      else if (hw_step[c])
        cnt_r[c] <= cnt_r[c] - CNT_LAST;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control: hardware ends the channel and sets the done flag; the set beats a clear.
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        ctl_r[c] <= CTL_RESET;
      end
    end
    else
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        if (wr_ctl[c])
        begin
          if (c < NUM_EXT_CH)
            ctl_r[c] <= pwdata_i & CTL_WM_EXT;
          else
            ctl_r[c] <= pwdata_i & CTL_WM_INT;
          if (hw_last[c])
            ctl_r[c][B_DONE] <= 1'b1;
        end
        else if (hw_last[c])
        begin
          ctl_r[c][B_EN]   <= 1'b0;
          ctl_r[c][B_DONE] <= 1'b1;
        end
      end
    end
  end

  always_comb
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      ch_busy_o[c] = (state_r != ST_IDLE) && (cur_r == 2'(c));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Handshake pins with programmable active level.
  // Pins decode registered state only, so bus traffic cannot make them glitch.
  always_comb
  begin
    for (int c = 0; c < NUM_EXT_CH; c++)
    begin
      logic act;
      logic ack_act;
      logic end_act;
      act     = (state_r != ST_IDLE) && (cur_r == 2'(c)) && ext_use[c];
      ack_act = 1'b0;
      if (act && cur_single)
        ack_act = 1'b1;
      else if (act && ctl_r[c][B_AM])
        ack_act = (state_r == ST_WR);
      else if (act)
        ack_act = (state_r == ST_RD);
      end_act = act && cur_last;
      ext_ack_out_o[c]  = ~(ack_act ^ ctl_r[c][B_AL]);
      xfer_end_out_o[c] = ~(end_act ^ ctl_r[c][B_TL]);
    end
  end
endmodule
`default_nettype wire

// ==== logic/dmach_pkg.sv ====
// Package with register map, field layout and encodings of the DMA channel block.
package dmach_pkg;
  localparam int          NUM_CH      = 4;
  localparam int          NUM_EXT_CH  = 2;
  localparam int          CNT_W       = 24;
  // Byte offsets inside one channel window and the channel window stride.
  localparam logic [7:0]  OFS_SRC     = 8'h00;
  localparam logic [7:0]  OFS_DST     = 8'h04;
  localparam logic [7:0]  OFS_CNT     = 8'h08;
  localparam logic [7:0]  OFS_CTL     = 8'h0C;
  localparam int          CH_SHIFT    = 4;
  localparam logic [7:0]  MAP_END     = 8'h40;
  // Control register fields.
  localparam int          B_EN        = 0;
  localparam int          B_DONE      = 1;
  localparam int          B_DET_LO    = 2;
  localparam int          B_SIZE_LO   = 4;
  localparam int          B_RS_LO     = 8;
  localparam int          B_SM_LO     = 12;
  localparam int          B_DM_LO     = 14;
  localparam int          B_AL        = 16;
  localparam int          B_AM        = 17;
  localparam int          B_TL        = 22;
  localparam int          B_DO        = 23;
  localparam logic [31:0] CTL_RESET   = 32'h0000_0000;
  localparam logic [31:0] CTL_WM_EXT  = 32'h00C3_FF3D;
  localparam logic [31:0] CTL_WM_INT  = 32'h0000_FF31;
  localparam logic [31:0] DONE_MASK   = 32'h0000_0002;
  localparam logic [CNT_W-1:0] CNT_LAST = 24'h00_0001;
  // Request detection modes.
  localparam logic [1:0]  DET_LOW     = 2'h0;
  localparam logic [1:0]  DET_HIGH    = 2'h1;
  localparam logic [1:0]  DET_RISE    = 2'h2;
  localparam logic [1:0]  DET_FALL    = 2'h3;
  // Address modes.
  localparam logic [1:0]  AM_FIXED    = 2'h0;
  localparam logic [1:0]  AM_INC      = 2'h1;
  localparam logic [1:0]  AM_DEC      = 2'h2;
  // Resource select codes that use the external request.
  localparam logic [3:0]  RS_EXT_DUAL = 4'h0;
  localparam logic [3:0]  RS_EXT_TOD  = 4'h2;
  localparam logic [3:0]  RS_EXT_FROM = 4'h3;
  // Transfer unit: byte, word, longword, 16 bytes.
  localparam logic [1:0]  SZ_BYTE     = 2'h0;
  localparam logic [1:0]  SZ_WORD     = 2'h1;
  localparam logic [1:0]  SZ_LONG     = 2'h2;
  localparam logic [1:0]  SZ_16B      = 2'h3;
  localparam logic [31:0] STEP_B      = 32'h0000_0001;
  localparam logic [31:0] STEP_W      = 32'h0000_0002;
  localparam logic [31:0] STEP_L      = 32'h0000_0004;
  localparam logic [31:0] STEP_16     = 32'h0000_0010;
  localparam logic [1:0]  PEND_ONE    = 2'h1;
  localparam logic [1:0]  PEND_TWO    = 2'h2;
  // Transfer engine states, Gray coded along idle, read, write.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RD   = 2'b01,
    ST_WR   = 2'b11
  } dmach_state_t;
endpackage

// ==== logic/dmach_req_det.sv ====
// Request pin synchroniser and level or edge detector for one external channel.
`timescale 1ns/1ps
`default_nettype none
module dmach_req_det
  import dmach_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       req_pin_i,
  input  wire logic [1:0] det_mode_i,
  input  wire logic       overrun_sel_i,
  input  wire logic       take_i,
  output logic            pending_o
);
  logic       sync1_r;
  logic       sync2_r;
  logic       prev_r;
  logic [1:0] pend_r;
  logic       edge_hit;
  logic       is_edge;
  logic [1:0] pend_cap;

  ////////////////////////////////////////////////////////////////////////////////
  // Two flip-flops carry the pin into the clock domain.
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
    end
    else
    begin
      sync1_r <= req_pin_i;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Edges are latched; overrun 1 holds a second edge while one is still pending.
  assign is_edge  = det_mode_i[1];
  assign edge_hit = (det_mode_i == DET_RISE) ? (sync2_r & ~prev_r) : (~sync2_r & prev_r);
  assign pend_cap = overrun_sel_i ? PEND_TWO : PEND_ONE;

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      pend_r <= 2'h0;
    else if (!is_edge)
      pend_r <= 2'h0;
    else if (edge_hit && !take_i && pend_r < pend_cap)
      pend_r <= pend_r + PEND_ONE;
    else if (!edge_hit && take_i && pend_r != 2'h0)
      pend_r <= pend_r - PEND_ONE;
  end

  always_comb
  begin
    case (det_mode_i)
      DET_LOW:  pending_o = ~sync2_r;
      DET_HIGH: pending_o = sync2_r;
      default:  pending_o = (pend_r != 2'h0);
    endcase
  end
endmodule
`default_nettype wire

// ==== testbench/dmach_top_asserts.sv ====
// Port checker of the DMA channel block.
`timescale 1ns/1ps
`default_nettype none
module dmach_top_asserts
  import dmach_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [7:0]            paddr_i,
  input  wire logic [31:0]           pwdata_i,
  input  wire logic [31:0]           prdata_o,
  input  wire logic [NUM_EXT_CH-1:0] ext_ack_out_o,
  input  wire logic [NUM_EXT_CH-1:0] xfer_end_out_o,
  input  wire logic [NUM_CH-1:0]     ch_busy_o
);
  logic [1:0][31:0] ctl_r;
  logic             rd_acc;
  logic             ack0;
  assign rd_acc = psel_i && penable_i && !pwrite_i && paddr_i[7:6] == 2'h0 && paddr_i[1:0] == 2'h0;
  assign ack0   = ext_ack_out_o[0] == ctl_r[0][B_AL];
  // Shadow of the control words of the two external channels.
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      ctl_r <= '0;
    else if (psel_i && penable_i && pwrite_i && paddr_i[7:5] == 3'h0 && paddr_i[3:0] == 4'hC)
      ctl_r[paddr_i[4]] <= pwdata_i;
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  //////////////////////////////////////////////////
  AST_CNT_TOP: assert property (rd_acc && paddr_i[3:0] == 4'h8 |-> prdata_o[31:24] == 8'h00)
    else $error("count top byte not zero");
  AST_CTL_RSV: assert property (rd_acc && paddr_i[3:0] == 4'hC |->
    prdata_o[31:24] == 8'h00 && prdata_o[21:18] == 4'h0)
    else $error("control reserved bits not zero");
  AST_CH23_ZERO: assert property (rd_acc && paddr_i[5] && paddr_i[3:0] == 4'hC |->
    {prdata_o[23:22], prdata_o[17:16]} == 4'h0)
    else $error("pin bits of internal channel not zero");
  AST_ACK_IDLE: assert property ((ch_busy_o[0] || ext_ack_out_o[0] != ctl_r[0][B_AL]) &&
    (ch_busy_o[1] || ext_ack_out_o[1] != ctl_r[1][B_AL]))
    else $error("acknowledge active while idle");
  AST_END_IDLE: assert property ((ch_busy_o[0] || xfer_end_out_o[0] != ctl_r[0][B_TL]) &&
    (ch_busy_o[1] || xfer_end_out_o[1] != ctl_r[1][B_TL]))
    else $error("transfer end active while idle");
  AST_ONE_CH: assert property ($onehot0(ch_busy_o))
    else $error("two channels serviced at once");
  AST_BUSY_SHORT: assert property (ch_busy_o[0] |-> ##[1:2] !ch_busy_o[0])
    else $error("transfer longer than two cycles");
  AST_ACK_DUAL: assert property (ch_busy_o[0] && ctl_r[0][11:8] == RS_EXT_DUAL |->
    ack0 == ($past(ch_busy_o[0]) == ctl_r[0][B_AM]))
    else $error("acknowledge in wrong dual phase");
  AST_ACK_SGL: assert property (ch_busy_o[0] && ctl_r[0][11:9] == 3'h1 |-> ack0)
    else $error("acknowledge missing in single mode");
endmodule
bind dmach_top dmach_top_asserts chk_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .ext_ack_out_o(ext_ack_out_o), .xfer_end_out_o(xfer_end_out_o),
  .ch_busy_o(ch_busy_o));
`default_nettype wire

// ==== testbench/dmach_ext_dev.sv ====
// Behavioural external requester for one handshake channel.
`timescale 1ns/1ps
`default_nettype none
module dmach_ext_dev
(
  input  wire logic clk_i,
  input  wire logic go_i,
  input  wire logic req_hi_i,
  input  wire logic ack_hi_i,
  input  wire logic ack_i,
  output logic      req_o
);
  logic want_r;
  int   gap_r;
  initial
  begin
    want_r = 1'b0;
    gap_r  = 0;
  end
  // Requests, drops the request once acknowledged, then waits a random gap.
  always @(posedge clk_i)
  begin
    if (!go_i)
      want_r <= 1'b0;
    else if (want_r && ack_i === ack_hi_i)
    begin
      want_r <= 1'b0;
      gap_r  <= $urandom_range(3, 0);
    end
    else if (!want_r && gap_r == 0)
      want_r <= 1'b1;
    else if (!want_r)
      gap_r <= gap_r - 1;
  end
  assign req_o = want_r ? req_hi_i : !req_hi_i;
endmodule
`default_nettype wire

// ==== testbench/dma_channel_regs_and_handshake_bench.sv ====
// Self-checking bench of the DMA channel block with two external requesters.
`timescale 1ns/1ps
`default_nettype none
module dma_channel_regs_and_handshake_bench
  import dmach_pkg::*;
;
  logic        clk_i, sys_rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, errv;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, rdv;
  logic [1:0]  req, ack, xfer_end_out, go, req_hi, al_c, tl_c;
  logic [3:0]  busy;
  int          failures, comparisons, ack_n [2], end_n [2];
  logic [3:0]  rs_tbl [3] = '{RS_EXT_DUAL, RS_EXT_TOD, RS_EXT_FROM};

  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  dmach_top dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .prdata_o(prdata_o), .ext_request_in_i(req), .ext_ack_out_o(ack),
    .xfer_end_out_o(xfer_end_out), .ch_busy_o(busy));

  for (genvar g = 0; g < 2; g++)
  begin : g_dev
    dmach_ext_dev dev_u (.clk_i(clk_i), .go_i(go[g]), .req_hi_i(req_hi[g]),
      .ack_hi_i(al_c[g]), .ack_i(ack[g]), .req_o(req[g]));
  end

  // Counts the cycles in which each pin is active.
  always @(negedge clk_i)
  begin
    for (int c = 0; c < 2; c++)
    begin
      if (ack[c] === al_c[c])
        ack_n[c]++;
      if (xfer_end_out[c] === tl_c[c])
        end_n[c]++;
    end
  end
  //////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    if (failures == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int k;
    @(posedge clk_i);
    psel_i    <= 1'b1;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (pready_o !== 1'b1 && k < 20);
    if (k >= 20)
    begin
      failures++;
      wrap_up();
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rdv, errv);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rdv, errv);
    chk(rdv, exp);
  endtask

  function automatic logic [31:0] nxt(input logic [31:0] p, input logic [1:0] m,
                                      input logic [31:0] st, input int n);
    if (m == AM_INC)
      return p + st * n;
    if (m == AM_DEC)
      return p - st * n;
    return p;
  endfunction
  //////////////////////////////////////////////////
  task automatic run(input int ch, input int i);
    logic [31:0] s, d, cfg, st;
    logic [7:0]  b;
    logic [3:0]  rs;
    logic [1:0]  sz, sm, dm, det;
    logic        al, am, tl, ov, ext;
    int          n, k;
    ext = ch < 2;
    b = 8'(ch * 16);
    n = $urandom_range(3, 1);
    sz = 2'($urandom_range(3, 0));
    sm = sz == SZ_16B ? AM_INC : 2'($urandom_range(2, 0));
    dm = sz == SZ_16B ? AM_INC : 2'($urandom_range(2, 0));
    st = sz == SZ_16B ? STEP_16 : STEP_B << sz;
    s = $urandom & ~(st - 1);
    d = $urandom & ~(st - 1);
    {al, am, tl, ov} = ext ? 4'($urandom) : 4'h0;
    det = ext ? 2'(i / 4) : DET_LOW;
    rs = ext ? rs_tbl[(i / 4) % 3] : 4'h4;
    if (ext)
    begin
      al_c[ch]   <= al;
      tl_c[ch]   <= tl;
      req_hi[ch] <= det == DET_HIGH || det == DET_RISE;
    end
    cfg = {8'h00, ov, tl, 4'h0, am, al, dm, sm, rs, 2'h0, sz, det, 2'h0};
    wr(b, s);
    wr(b + 8'h4, d);
    wr(b + 8'h8, 32'(n));
    wr(b + 8'hC, cfg);
    ack_n = '{0, 0};
    end_n = '{0, 0};
    wr(b + 8'hC, cfg | 32'h1);
    if (ext)
      go[ch] <= 1'b1;
    k = 0;
    do
    begin
      apb(1'b0, b + 8'hC, 32'h0, rdv, errv);
      k++;
    end
    while (rdv[B_EN] !== 1'b0 && k < 100);
    if (k >= 100)
    begin
      failures++;
      wrap_up();
    end
    if (ext)
      go[ch] <= 1'b0;
    chk(rdv, cfg | DONE_MASK);
    rdc(b, rs == RS_EXT_FROM ? s : nxt(s, sm, st, n));
    rdc(b + 8'h4, rs == RS_EXT_TOD ? d : nxt(d, dm, st, n));
    rdc(b + 8'h8, 32'h0);
    if (ext)
    begin
      chk(ack_n[ch], n);
      chk(end_n[ch], rs == RS_EXT_DUAL ? 2 : 1);
    end
    else
      chk(ack_n[0] + ack_n[1] + end_n[0] + end_n[1], 0);
    wr(b + 8'hC, 32'h0);
    if (ext)
    begin
      al_c[ch] <= 1'b0;
      tl_c[ch] <= 1'b0;
    end
  endtask
  //////////////////////////////////////////////////
  initial
  begin
    logic [7:0]  b;
    logic [31:0] v;
    failures = 0;
    comparisons = 0;
    sys_rst_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    go = 2'h0;
    req_hi = 2'h0;
    al_c = 2'h0;
    tl_c = 2'h0;
    void'($urandom(4));
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    chk({28'h0, ack, xfer_end_out}, 32'hF);
    for (int ch = 0; ch < 4; ch++)
    begin
      b = 8'(ch * 16);
      rdc(b + 8'hC, CTL_RESET);
      v = $urandom;
      wr(b, v);
      rdc(b, v);
      v = $urandom;
      wr(b + 8'h4, v);
      rdc(b + 8'h4, v);
      v = $urandom;
      wr(b + 8'h8, v);
      rdc(b + 8'h8, v & 32'h00FF_FFFF);
      v = $urandom & 32'hFFFF_FFFE;
      wr(b + 8'hC, v);
      rdc(b + 8'hC, v & (ch < 2 ? CTL_WM_EXT : CTL_WM_INT));
      wr(b + 8'hC, 32'h0);
    end
    rdc(MAP_END, 32'h0);
    chk(32'(errv), 32'h1);
    for (int i = 0; i < 24; i++)
      run(i % 4, i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rdc(8'h1C, CTL_RESET);
    wrap_up();
  end
endmodule
`default_nettype wire
